// >>> common/sdi_pkg.sv
// Constants, command codes and state types of the SDRAM power-up sequence tracker
// How it works
// - Clock enable is registered on three consecutive edges before it may change.
// - Mode bit 10 selects strobe: 0 differential, 1 single-ended.
// - Accesses are bursts of four or eight, an activate then read or write.
// - Activate gives bank and row; read or write gives column and auto-precharge.
package sdi_pkg;

	localparam int ADDR_W = 16;
	localparam int BA_W = 2;
	localparam int ROW_W = 13;
	localparam int COL_W = 10;
	localparam int NBANK = 4;

	localparam int T_CKE_WAIT_NS = 400;
	localparam int DLL_LOCK_CLK = 200;
	localparam int CAL_GAP_CLK = 200;
	localparam int WTR_CLK = 2;
	localparam int CKE_MIN_CLK = 3;
	localparam int REF_MIN_CNT = 2;
	localparam int CNT_W = 9;

	// Command codes as {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;

	localparam logic [1:0] MREG_MR = 2'h0;
	localparam logic [1:0] MREG_EMR1 = 2'h1;
	localparam logic [1:0] MREG_EMR2 = 2'h2;
	localparam logic [1:0] MREG_EMR3 = 2'h3;

	localparam int BIT_DLL_OFF = 0;
	localparam int BIT_DLL_RST = 8;
	localparam int BIT_AP = 10;
	localparam int BIT_STROBE_SE = 10;
	localparam int BIT_QOFF = 12;
	localparam int OCD_LO = 7;
	localparam int OCD_HI = 9;
	localparam int BL_LO = 0;
	localparam int BL_HI = 2;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] OCD_DEFAULT = 3'h7;
	localparam logic [2:0] OCD_EXIT = 3'h0;

	// Sticky error bit positions
	localparam int ERR_SEQ = 0;
	localparam int ERR_CKE_WAIT = 1;
	localparam int ERR_MRD = 2;
	localparam int ERR_CAL_EARLY = 3;
	localparam int ERR_DLL_READ = 4;
	localparam int ERR_WTR = 5;
	localparam int ERR_CKE_PULSE = 6;
	localparam int ERR_ACCESS = 7;
	localparam int ERR_W = 8;

	typedef enum logic [3:0] {
		ST_WAIT_CKE = 4'h0,
		ST_WAIT_PRE1 = 4'h1,
		ST_WAIT_EMR2 = 4'h2,
		ST_WAIT_EMR3 = 4'h3,
		ST_WAIT_DLLEN = 4'h4,
		ST_WAIT_DLLRST = 4'h5,
		ST_WAIT_PRE2 = 4'h6,
		ST_WAIT_REF = 4'h7,
		ST_WAIT_MROP = 4'h8,
		ST_WAIT_OCDDEF = 4'h9,
		ST_WAIT_OCDEXIT = 4'ha,
		ST_READY = 4'hb
	} sdi_state_e;

endpackage

// >>> design/sdi_init_seq.sv
// SDRAM side power-up sequence tracker, command decode and status
`timescale 1ns/1ps
`default_nettype none
module sdi_init_seq
	import sdi_pkg::*;
#(
	parameter int CK_PERIOD_PS = 30000,
	parameter int MRD_CLK = 2
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic mem_ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic odt,
	output logic acc_act,
	output logic acc_rd,
	output logic acc_wr,
	output logic [BA_W-1:0] acc_bank,
	output logic [ROW_W-1:0] acc_row,
	output logic [COL_W-1:0] acc_col,
	output logic acc_auto_pre,
	output logic init_done,
	output logic strobe_single,
	output logic burst8,
	output logic odt_seen,
	output logic [ERR_W-1:0] err_flags
);

	localparam int CKE_WAIT_CLK = (T_CKE_WAIT_NS * 1000 + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int NSYNC = ERR_W + 4;

	function automatic logic [2:0] dec_cmd(input logic rn, input logic cn, input logic wn);
		dec_cmd = {rn, cn, wn};
	endfunction

	// Reset crossing into the link domain; the link clock must run while sys_rst is held
	logic rst_m_q, link_rst_q;
	always_ff @(posedge mem_ck) begin
		rst_m_q <= sys_rst;
		link_rst_q <= rst_m_q;
	end

	// Clock enable filter: level accepted only after three equal samples
	logic [1:0] cke_run_q;
	logic cke_last_q, cke_valid_q;
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			cke_last_q <= 1'b0;
			cke_run_q <= 2'h0;
			cke_valid_q <= 1'b0;
		end else begin
			cke_last_q <= cke;
			if (cke != cke_last_q) begin
				cke_run_q <= 2'h1;
			end else if (cke_run_q != 2'(CKE_MIN_CLK)) begin
				cke_run_q <= cke_run_q + 2'h1;
			end
			if (cke == cke_last_q && cke_run_q == 2'(CKE_MIN_CLK - 1)) begin
				cke_valid_q <= cke;
			end
		end
	end
	wire logic cke_short = (cke != cke_last_q) && (cke_run_q != 2'(CKE_MIN_CLK)) && (cke_run_q != 2'h0);

	// Decode is live only while clock enable is registered high
	logic [2:0] cmd;
	always_comb begin
		cmd = CMD_NOP;
		if (!cs_n && cke_valid_q && cke) begin
			cmd = dec_cmd(ras_n, cas_n, we_n);
		end
	end
	wire logic is_mrs = (cmd == CMD_MRS);
	wire logic is_pre_all = (cmd == CMD_PRE) && addr[BIT_AP];
	wire logic is_other = (cmd != CMD_NOP);
	wire logic [2:0] ocd_code = addr[OCD_HI:OCD_LO];

	sdi_state_e state_q;
	logic [CNT_W-1:0] cke_cnt_q, dll_cnt_q, mrd_cnt_q, wtr_cnt_q;
	logic [1:0] ref_cnt_q;
	logic [NBANK-1:0] open_q;
	logic [ERR_W-1:0] err_q;
	logic seq_bad;

	// Init state walk; a wrong command leaves the step to be retried, and is flagged if of another kind, or a mode write to a wrong register in ST_WAIT_REF
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			state_q <= ST_WAIT_CKE;
		end else begin
			case (state_q)
				ST_WAIT_CKE: if (cke_valid_q) state_q <= ST_WAIT_PRE1;
				ST_WAIT_PRE1: if (is_pre_all) state_q <= ST_WAIT_EMR2;
				ST_WAIT_EMR2: if (is_mrs && ba == MREG_EMR2) state_q <= ST_WAIT_EMR3;
				ST_WAIT_EMR3: if (is_mrs && ba == MREG_EMR3) state_q <= ST_WAIT_DLLEN;
				ST_WAIT_DLLEN: begin
					if (is_mrs && ba == MREG_EMR1 && !addr[BIT_DLL_OFF] && !addr[BIT_QOFF]) begin
						state_q <= ST_WAIT_DLLRST;
					end
				end
				ST_WAIT_DLLRST: if (is_mrs && ba == MREG_MR && addr[BIT_DLL_RST]) state_q <= ST_WAIT_PRE2;
				ST_WAIT_PRE2: if (is_pre_all) state_q <= ST_WAIT_REF;
				ST_WAIT_REF: begin
					if (is_mrs && ba == MREG_MR && !addr[BIT_DLL_RST] && ref_cnt_q == 2'(REF_MIN_CNT)) begin
						state_q <= ST_WAIT_OCDDEF;
					end
				end
				ST_WAIT_OCDDEF: begin
					if (is_mrs && ba == MREG_EMR1 && ocd_code == OCD_DEFAULT) begin
						state_q <= ST_WAIT_OCDEXIT;
					end
				end
				ST_WAIT_OCDEXIT: begin
					if (is_mrs && ba == MREG_EMR1 && ocd_code == OCD_EXIT) begin
						state_q <= ST_READY;
					end
				end
				ST_READY: state_q <= ST_READY;
				default: state_q <= ST_WAIT_CKE;
			endcase
		end
	end

	// Any command of another kind than the expected one (or NOP) during init; a mode write to the wrong register is flagged only in ST_WAIT_REF
	always_comb begin
		seq_bad = 1'b0;
		case (state_q)
			ST_WAIT_CKE, ST_WAIT_PRE1: seq_bad = is_other && !is_pre_all;
			ST_WAIT_PRE2: seq_bad = is_other && !is_pre_all;
			ST_WAIT_REF: seq_bad = is_other && (cmd != CMD_REF) && !(is_mrs && ba == MREG_MR);
			ST_WAIT_EMR2, ST_WAIT_EMR3, ST_WAIT_DLLEN, ST_WAIT_DLLRST,
			ST_WAIT_OCDDEF, ST_WAIT_OCDEXIT: seq_bad = is_other && !is_mrs;
			ST_READY: seq_bad = 1'b0;
			default: seq_bad = 1'b0;
		endcase
	end

	always_ff @(posedge mem_ck) begin
		if (link_rst_q || state_q != ST_WAIT_REF) begin
			ref_cnt_q <= 2'h0;
		end else if (cmd == CMD_REF && ref_cnt_q != 2'(REF_MIN_CNT)) begin
			ref_cnt_q <= ref_cnt_q + 2'h1;
		end
	end

	// Cycles since clock enable was registered high
	always_ff @(posedge mem_ck) begin
		if (link_rst_q || !cke_valid_q) begin
			cke_cnt_q <= '0;
		end else if (cke_cnt_q != CNT_W'(CKE_WAIT_CLK)) begin
			cke_cnt_q <= cke_cnt_q + 1'b1;
		end
	end

	// Cycles since the last DLL reset; saturates at the lock time
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			dll_cnt_q <= '0;
		end else if (is_mrs && ba == MREG_MR && addr[BIT_DLL_RST]) begin
			dll_cnt_q <= '0;
		end else if (dll_cnt_q != CNT_W'(DLL_LOCK_CLK)) begin
			dll_cnt_q <= dll_cnt_q + 1'b1;
		end
	end

	// Mode write cycle time and write-to-read spacing
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			mrd_cnt_q <= CNT_W'(MRD_CLK);
			wtr_cnt_q <= CNT_W'(WTR_CLK);
		end else begin
			if (is_mrs) mrd_cnt_q <= '0;
			else if (mrd_cnt_q != CNT_W'(MRD_CLK)) mrd_cnt_q <= mrd_cnt_q + 1'b1;
			if (cmd == CMD_WR) wtr_cnt_q <= '0;
			else if (wtr_cnt_q != CNT_W'(WTR_CLK)) wtr_cnt_q <= wtr_cnt_q + 1'b1;
		end
	end

	wire logic ready = (state_q == ST_READY);
	wire logic acc_ok_act = ready && cmd == CMD_ACT && !open_q[ba];
	wire logic acc_ok_rw = ready && (cmd == CMD_RD || cmd == CMD_WR) && open_q[ba];

	// Open-bank tracking; auto-precharge closes the bank on the edge that takes the read or write
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			open_q <= '0;
		end else if (is_pre_all) begin
			open_q <= '0;
		end else if (cmd == CMD_PRE) begin
			open_q[ba] <= 1'b0;
		end else if (acc_ok_act) begin
			open_q[ba] <= 1'b1;
		end else if (acc_ok_rw && addr[BIT_AP]) begin
			open_q[ba] <= 1'b0;
		end
	end

	// Sticky errors, cleared only by reset
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			err_q <= '0;
		end else begin
			if (seq_bad) err_q[ERR_SEQ] <= 1'b1;
			if (is_pre_all && state_q == ST_WAIT_PRE1 && cke_cnt_q < CNT_W'(CKE_WAIT_CLK)) begin
				err_q[ERR_CKE_WAIT] <= 1'b1;
			end
			if (is_other && mrd_cnt_q < CNT_W'(MRD_CLK)) err_q[ERR_MRD] <= 1'b1;
			if (is_mrs && open_q != '0) err_q[ERR_MRD] <= 1'b1;
			if (is_mrs && ba == MREG_EMR1 && ocd_code != OCD_EXIT && dll_cnt_q < CNT_W'(CAL_GAP_CLK)) begin
				err_q[ERR_CAL_EARLY] <= 1'b1;
			end
			if (cmd == CMD_RD && dll_cnt_q < CNT_W'(DLL_LOCK_CLK)) err_q[ERR_DLL_READ] <= 1'b1;
			if (cmd == CMD_RD && wtr_cnt_q < CNT_W'(WTR_CLK)) err_q[ERR_WTR] <= 1'b1;
			if (cke_short) err_q[ERR_CKE_PULSE] <= 1'b1;
			if ((cmd == CMD_ACT || cmd == CMD_RD || cmd == CMD_WR) && !(acc_ok_act || acc_ok_rw)) begin
				err_q[ERR_ACCESS] <= 1'b1;
			end
		end
	end

	// Access report in the link domain
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			acc_act <= 1'b0;
			acc_rd <= 1'b0;
			acc_wr <= 1'b0;
			acc_bank <= '0;
			acc_row <= '0;
			acc_col <= '0;
			acc_auto_pre <= 1'b0;
		end else begin
			acc_act <= acc_ok_act;
			acc_rd <= acc_ok_rw && cmd == CMD_RD;
			acc_wr <= acc_ok_rw && cmd == CMD_WR;
			if (acc_ok_act) begin
				acc_bank <= ba;
				acc_row <= addr[ROW_W-1:0];
			end
			if (acc_ok_rw) begin
				acc_bank <= ba;
				acc_col <= addr[COL_W-1:0];
				acc_auto_pre <= addr[BIT_AP];
			end
		end
	end

	logic [ADDR_W-1:0] mr_word;
	sdi_mode_mem #(.WIDTH(ADDR_W), .DEPTH(NBANK), .AW(BA_W)) u_mode_mem (
		.clk(mem_ck),
		.wr_en(is_mrs),
		.wr_addr(ba),
		.wr_data(addr),
		.rd_addr(MREG_MR),
		.rd_data(mr_word)
	);

	// Status levels held in the link domain before crossing
	logic [NSYNC-1:0] link_stat_q;
	always_ff @(posedge mem_ck) begin
		if (link_rst_q) begin
			link_stat_q <= '0;
		end else begin
			link_stat_q[ERR_W-1:0] <= err_q;
			link_stat_q[ERR_W] <= ready;
			link_stat_q[ERR_W+1] <= ready && mr_word[BIT_STROBE_SE];
			link_stat_q[ERR_W+2] <= ready && mr_word[BL_HI:BL_LO] == BL_CODE_8;
			link_stat_q[ERR_W+3] <= odt;
		end
	end

	// Each bit is a slow level, so a per-bit two-stage synchroniser is enough
	logic [NSYNC-1:0] sync_m_q, sync_q;
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					sync_m_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end else begin
					sync_m_q[gi] <= link_stat_q[gi];
					sync_q[gi] <= sync_m_q[gi];
				end
			end
		end
	endgenerate

	assign err_flags = sync_q[ERR_W-1:0];
	assign init_done = sync_q[ERR_W];
	assign strobe_single = sync_q[ERR_W+1];
	assign burst8 = sync_q[ERR_W+2];
	assign odt_seen = sync_q[ERR_W+3];

endmodule
`default_nettype wire

// >>> design/sdi_mode_mem.sv
// Mode register storage: four words, one write port, registered read
`timescale 1ns/1ps
`default_nettype none
module sdi_mode_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	// No reset: contents are undefined until mode register set commands write them
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem_q[rd_addr];
	end

endmodule
`default_nettype wire

// >>> verification/sdi_ctrl_model.sv
// Controller model driving clock enable, termination and commands on the link clock
`timescale 1ns/1ps
`default_nettype none
module sdi_ctrl_model
	import sdi_pkg::*;
#(parameter int PWR_WAIT_CLK = 20) (
	input wire logic mem_ck,
	output var logic cke,
	output var logic cs_n,
	output var logic ras_n,
	output var logic cas_n,
	output var logic we_n,
	output var logic [BA_W-1:0] ba,
	output var logic [ADDR_W-1:0] addr,
	output var logic odt
);
	initial begin
		{cke, odt, cs_n, ras_n, cas_n, we_n} = 6'h0f;
		ba = '0;
		addr = '0;
	end
	// Deselected lines flip so a stale value never passes for a field
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge mem_ck);
			#1 cs_n = 1'b1;
			ba = ~ba;
			addr = ~addr;
		end
	endtask
	task automatic cmd(input logic [2:0] c, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input int gap);
		@(posedge mem_ck);
		#1 {cs_n, ras_n, cas_n, we_n} = {1'b0, c};
		ba = b;
		addr = a;
		idle(gap);
	endtask
	task automatic halt();
		idle(1);
		cke = 1'b0;
		odt = 1'b0;
	endtask
	// Fault 1 early precharge, 2 wrong order, 3 early calibration, 4 short enable, 5 early access,
	// 6 short gap after a mode write, 7 read while the DLL is still locking
	task automatic power_up(input int fault, input logic [ADDR_W-1:0] mr);
		idle(PWR_WAIT_CLK);
		cke = 1'b1;
		if (fault == 4) begin
			idle(2);
			cke = 1'b0;
			idle(3);
			cke = 1'b1;
		end
		idle(fault == 1 ? 4 : 17);
		if (fault == 5) cmd(CMD_ACT, 2'h1, 16'h0, 2);
		cmd(CMD_PRE, 2'h0, 16'h0400, 2);
		cmd(CMD_MRS, fault == 2 ? MREG_EMR3 : MREG_EMR2, 16'h0, fault == 6 ? 1 : 2);
		cmd(CMD_MRS, MREG_EMR3, 16'h0, 2);
		cmd(CMD_MRS, MREG_EMR1, 16'h0, 2);
		cmd(CMD_MRS, MREG_MR, 16'h0100, 2);
		if (fault == 7) cmd(CMD_RD, 2'h0, 16'h0, 2);
		cmd(CMD_PRE, 2'h0, 16'h0400, 2);
		cmd(CMD_REF, 2'h0, 16'h0, 2);
		cmd(CMD_REF, 2'h0, 16'h0, 2);
		cmd(CMD_MRS, MREG_MR, mr, 2);
		if (fault != 3) idle(200);
		cmd(CMD_MRS, MREG_EMR1, 16'h0380, 2);
		cmd(CMD_MRS, MREG_EMR1, 16'h0, 2);
	endtask
endmodule
`default_nettype wire

// >>> verification/sdi_init_seq_properties.sv
// Concurrent checks on the ports of the power-up sequence tracker
`timescale 1ns/1ps
`default_nettype none
module sdi_init_seq_properties
	import sdi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic mem_ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic acc_act,
	input wire logic acc_rd,
	input wire logic acc_wr,
	input wire logic [BA_W-1:0] acc_bank,
	input wire logic [ROW_W-1:0] acc_row,
	input wire logic [COL_W-1:0] acc_col,
	input wire logic acc_auto_pre,
	input wire logic init_done,
	input wire logic strobe_single,
	input wire logic burst8,
	input wire logic [ERR_W-1:0] err_flags
);
	// Link-side reset lags sys_rst by two link edges; keep link checks off until it has passed
	logic rst_m_q, link_rst_q;
	always_ff @(posedge mem_ck) begin
		rst_m_q <= sys_rst;
		link_rst_q <= rst_m_q;
	end
	act_cmd_a: assert property (@(posedge mem_ck) disable iff (sys_rst || link_rst_q)
		acc_act |-> !$past(cs_n) && !$past(ras_n) && $past(cas_n) && $past(we_n))
		else $error("activate pulse without command");
	rw_cmd_a: assert property (@(posedge mem_ck) disable iff (sys_rst || link_rst_q)
		(acc_rd || acc_wr) |-> !$past(cs_n) && $past(ras_n) && !$past(cas_n) && $past(we_n) == acc_rd)
		else $error("read or write pulse without command");
	act_addr_a: assert property (@(posedge mem_ck) disable iff (sys_rst || link_rst_q)
		acc_act |-> acc_bank == $past(ba) && acc_row == $past(addr[ROW_W-1:0]))
		else $error("bank or row not taken from activate");
	col_addr_a: assert property (@(posedge mem_ck) disable iff (sys_rst || link_rst_q)
		(acc_rd || acc_wr) |-> acc_col == $past(addr[COL_W-1:0]) && acc_auto_pre == $past(addr[BIT_AP]))
		else $error("column or auto precharge wrong");
	cke_held_a: assert property (@(posedge mem_ck) disable iff (sys_rst || link_rst_q)
		(acc_act || acc_rd || acc_wr) |-> $past(cke) && $past(cke, 2) && $past(cke, 3))
		else $error("access taken without three enable samples");
	err_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(err_flags & $past(err_flags)) == $past(err_flags))
		else $error("error flag cleared");
	done_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$past(init_done) |-> init_done)
		else $error("ready dropped");
	mode_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!init_done |-> !strobe_single && !burst8)
		else $error("mode outputs before ready");
endmodule
bind sdi_init_seq sdi_init_seq_properties chk (.*);
`default_nettype wire

// >>> verification/sdi_init_seq_tb.sv
// Self-checking bench for the power-up sequence tracker with a queue model of accepted accesses
`timescale 1ns/1ps
`default_nettype none
module sdi_init_seq_tb
	import sdi_pkg::*;
;
	localparam int LIMIT = 40000;
	localparam int CK_PS = 30000;
	localparam int WR_RECOV_CLK = 2;
	localparam int T_RP_PS = 15000;
	logic sys_clk = 1'b0;
	logic mem_ck = 1'b0;
	logic sys_rst = 1'b1;
	logic cke, cs_n, ras_n, cas_n, we_n, odt, acc_act, acc_rd, acc_wr, acc_auto_pre;
	logic init_done, strobe_single, burst8, odt_seen, wr_gap0;
	logic [BA_W-1:0] ba, acc_bank;
	logic [ADDR_W-1:0] addr, mr;
	logic [ROW_W-1:0] acc_row;
	logic [COL_W-1:0] acc_col;
	logic [ERR_W-1:0] err_flags, exp_err;
	logic [16:0] rnd = 17'h10fd7;
	logic [16:0] seen;
	logic [16:0] exp_q[$];
	logic open[4];
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int fbit[8] = '{0, ERR_CKE_WAIT, ERR_SEQ, ERR_CAL_EARLY, ERR_CKE_PULSE, ERR_ACCESS, ERR_MRD, ERR_DLL_READ};
	initial forever #2 sys_clk = ~sys_clk;
	// Link clock runs free at one fixed rate, phase unrelated to sys_clk
	initial begin
		#1.3;
		forever #15 mem_ck = ~mem_ck;
	end
	sdi_init_seq #(.CK_PERIOD_PS(30000), .MRD_CLK(2)) DUT (.*);
	sdi_ctrl_model #(.PWR_WAIT_CLK(20)) ctl (.*);
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	// Write recovery in clocks plus precharge time rounded up; writes here never auto-precharge, so it is a safe margin
	function automatic int dal_clk(input int nwr, input int trp_ps, input int tck_ps);
		return nwr + (trp_ps + tck_ps - 1) / tck_ps;
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) errors++;
		if (got !== exp) $display("mismatch %0s expected %0h seen %0h", what, exp, got);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic settle(input string name);
		repeat (40) @(posedge sys_clk);
		#1 check("pending accesses", 0, exp_q.size());
		$display("test %0s done", name);
	endtask
	// Enable drops before reset so the link side never sees a short enable pulse
	task automatic do_reset();
		ctl.halt();
		sys_rst = 1'b1;
		repeat (30) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		exp_err = '0;
		wr_gap0 = 1'b0;
		open = '{default: 1'b0};
	endtask
	task automatic acc(input logic [2:0] c, input int b, input int gap);
		logic [ADDR_W-1:0] a;
		logic ok;
		rnd = lfsr(rnd);
		a = rnd[15:0];
		if (c == CMD_WR) a[BIT_AP] = 1'b0;
		ok = (c == CMD_ACT) ? !open[b] : open[b];
		if (c == CMD_RD && wr_gap0) exp_err[ERR_WTR] = 1'b1;
		wr_gap0 = (c == CMD_WR && gap == 0);
		if (!ok) exp_err[ERR_ACCESS] = 1'b1;
		else if (c == CMD_ACT) exp_q.push_back({2'h1, 2'(b), a[ROW_W-1:0]});
		else exp_q.push_back({c == CMD_RD ? 2'h2 : 2'h3, 4'h0, a[BIT_AP], a[COL_W-1:0]});
		if (ok && c == CMD_ACT) open[b] = 1'b1;
		if (ok && c == CMD_RD && a[BIT_AP]) open[b] = 1'b0;
		ctl.cmd(c, 2'(b), a, gap);
	endtask
	// Pulses stand a full link cycle, so they are sampled mid-cycle; unknown until the first reset lands
	always @(negedge mem_ck) begin
		if (!sys_rst && (acc_act | acc_rd | acc_wr) !== 1'b0) begin
			seen = acc_act ? {2'h1, acc_bank, acc_row} : {acc_rd ? 2'h2 : 2'h3, 4'h0, acc_auto_pre, acc_col};
			if (exp_q.size() == 0) check("unexpected access", 0, 32'(seen));
			else check("access", 32'(exp_q.pop_front()), 32'(seen));
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		for (int f = 1; f <= 7; f++) begin
			do_reset();
			ctl.power_up(f, 16'h0002);
			settle("fault");
			check("fault flag", 1, err_flags[fbit[f]]);
		end
		for (int k = 0; k < 2; k++) begin
			do_reset();
			mr = k ? 16'h0403 : 16'h0002;
			ctl.power_up(0, mr);
			settle("init");
			check("ready", 1, init_done);
			check("strobe", mr[BIT_STROBE_SE], strobe_single);
			check("burst", mr[BL_HI:BL_LO] == BL_CODE_8, burst8);
			ctl.idle(1);
			ctl.odt = 1'b1;
			acc(CMD_ACT, 3, 2);
			acc(CMD_ACT, 3, 2);
			acc(CMD_RD, 2, 2);
			for (int b = 0; b < 4; b++) begin
				if (!open[b]) acc(CMD_ACT, b, 2);
				acc(CMD_WR, b, b == 1 ? 0 : dal_clk(WR_RECOV_CLK, T_RP_PS, CK_PS));
				acc(CMD_RD, b, 2);
			end
			settle("access");
			check("termination", 1, odt_seen);
			check("error flags", exp_err, err_flags);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
